// [logic/amps_regs.sv]
// I2C-reached status, soft-mute and clock-control registers 0x03 to 0x06
`timescale 1ns/10ps
`default_nettype none
module amps_regs #(
	parameter logic [4:0] DEV_ADDR_HI = 5'h16, // arbitrary upper address bits
	parameter int         GAIN_W      = 8
) (
	input  wire logic                     clk,         // master clock
	input  wire logic                     sys_rst,     // async reset, high
	input  wire logic [1:0]               devAddrSel,  // address select pins
	input  wire logic                     sclIn,       // I2C clock level
	input  wire logic                     sdaIn,       // I2C data level
	output logic                          sdaOut,      // I2C data drive value
	output logic                          sdaOe,       // high while pulling data low
	input  wire amps_regs_pkg::amps_stat_t stat,       // device status inputs
	output amps_regs_pkg::amps_ctl_t      ctl,         // clocking and standby controls
	output logic      [GAIN_W-1:0]        gainLeft,    // left soft-mute gain
	output logic      [GAIN_W-1:0]        gainRight    // right soft-mute gain
);
	if (GAIN_W < 2) begin : g_chk
		$error("amps_regs: GAIN_W too small");
	end

	amps_regs_pkg::amps_i2c_st_t st_ff, nxt_st;
	logic [7:0] shift_ff, nxt_shift;
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic       sclPrev_ff;
	logic       sdaPrev_ff;
	logic       sdaOe_ff, nxt_sdaOe;
	logic [6:0] ptr_ff, nxt_ptr;
	logic       incEn_ff, nxt_incEn;
	logic       gotPtr_ff, nxt_gotPtr;
	logic       rw_ff, nxt_rw;

	logic muteL_ff, nxt_muteL;
	logic muteR_ff, nxt_muteR;
	logic pllEn_ff, nxt_pllEn;
	logic autoOff_ff, nxt_autoOff;
	logic legacy_ff, nxt_legacy;

	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;
	logic       wrEn;
	logic       ptrLoad;
	logic       loadRd;
	logic [7:0] rdData;
	logic [7:0] reg3Img;
	logic [7:0] reg4Img;
	logic [7:0] reg5Img;
	logic [7:0] reg6Img;
	logic       bufEnable;
	logic       backendUp;
	logic       pllUnlocked;
	logic       oscPoweredDown;
	logic [6:0] devAddr;

	assign devAddr   = {DEV_ADDR_HI, devAddrSel};
	assign sclRise   = !sclPrev_ff && sclIn;
	assign sclFall   = sclPrev_ff && !sclIn;
	assign startCond = sclPrev_ff && sclIn && sdaPrev_ff && !sdaIn;
	assign stopCond  = sclPrev_ff && sclIn && !sdaPrev_ff && sdaIn;

	// status views
	assign bufEnable      = stat.ldoInPor && stat.ldoOutPor;
	assign backendUp      = stat.avddPor && stat.cpvddPor && stat.lineAmpUnmuted;
	assign pllUnlocked    = !pllEn_ff || !stat.pllLocked;
	assign oscPoweredDown = autoOff_ff && !stat.sysClkBad;

	// reserved bits are constant zero; read-only bits come from status, with 0x04 bit 4 and 0x05 bit 4 also gated by the written enables
	assign reg3Img = {stat.syncClk, bufEnable, backendUp, muteL_ff, 3'h0, muteR_ff};
	assign reg4Img = {3'h0, pllUnlocked, 3'h0, pllEn_ff};
	assign reg5Img = {2'h0, stat.sysClkBad, oscPoweredDown, 3'h0, autoOff_ff};
	assign reg6Img = {3'h0, legacy_ff, 4'h0};

	always_comb begin
		case (ptr_ff)
			amps_regs_pkg::OFS_BACKEND:  rdData = reg3Img;
			amps_regs_pkg::OFS_PLL:      rdData = reg4Img;
			amps_regs_pkg::OFS_OSC:      rdData = reg5Img;
			amps_regs_pkg::OFS_CTRLPORT: rdData = reg6Img;
			default:                     rdData = 8'h00;
		endcase
	end

	assign wrEn    = (st_ff == amps_regs_pkg::ST_WR_BYTE) && sclFall && gotPtr_ff
		&& (bitCnt_ff == 4'(amps_regs_pkg::I2C_BITS));
	assign ptrLoad = (st_ff == amps_regs_pkg::ST_WR_BYTE) && sclFall && !gotPtr_ff
		&& (bitCnt_ff == 4'(amps_regs_pkg::I2C_BITS));
	assign loadRd  = sclFall && (((st_ff == amps_regs_pkg::ST_ACK_ADR) && rw_ff)
		|| (st_ff == amps_regs_pkg::ST_ACK_RD));

	// control port engine
	always_comb begin
		nxt_st     = st_ff;
		nxt_shift  = shift_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_sdaOe  = sdaOe_ff;
		nxt_ptr    = ptr_ff;
		nxt_incEn  = incEn_ff;
		nxt_gotPtr = gotPtr_ff;
		nxt_rw     = rw_ff;
		if (startCond) begin
			nxt_st     = amps_regs_pkg::ST_ADDR;
			nxt_bitCnt = 4'h0;
			nxt_sdaOe  = 1'b0;
		end else if (stopCond) begin
			nxt_st    = amps_regs_pkg::ST_IDLE;
			nxt_sdaOe = 1'b0;
		end else begin
			case (st_ff)
				amps_regs_pkg::ST_IDLE: nxt_sdaOe = 1'b0;
				amps_regs_pkg::ST_ADDR, amps_regs_pkg::ST_WR_BYTE: begin
					if (sclRise) begin
						nxt_shift  = {shift_ff[6:0], sdaIn};
						nxt_bitCnt = bitCnt_ff + 4'h1;
					end else if (sclFall && bitCnt_ff == 4'(amps_regs_pkg::I2C_BITS)) begin
						nxt_bitCnt = 4'h0;
						if (st_ff == amps_regs_pkg::ST_WR_BYTE) begin
							nxt_st    = amps_regs_pkg::ST_ACK_WR;
							nxt_sdaOe = 1'b1;
							if (!gotPtr_ff) begin
								nxt_ptr    = shift_ff[6:0];
								// legacy style honours the address MSB; otherwise always step
								nxt_incEn  = legacy_ff ? shift_ff[amps_regs_pkg::BIT_AUTOINC] : 1'b1;
								nxt_gotPtr = 1'b1;
							end else if (incEn_ff) begin
								nxt_ptr = ptr_ff + 7'h01;
							end
						end else if (shift_ff[7:1] == devAddr) begin
							nxt_st     = amps_regs_pkg::ST_ACK_ADR;
							nxt_rw     = shift_ff[0];
							nxt_sdaOe  = 1'b1;
							nxt_gotPtr = shift_ff[0] ? gotPtr_ff : 1'b0;
						end else begin
							nxt_st = amps_regs_pkg::ST_IDLE;
						end
					end
				end
				amps_regs_pkg::ST_ACK_ADR, amps_regs_pkg::ST_ACK_WR: begin
					if (loadRd) begin
						nxt_st     = amps_regs_pkg::ST_RD_BYTE;
						nxt_shift  = {rdData[6:0], 1'b0};
						nxt_sdaOe  = !rdData[7];
						nxt_bitCnt = 4'h1;
					end else if (sclFall) begin
						nxt_st    = amps_regs_pkg::ST_WR_BYTE;
						nxt_sdaOe = 1'b0;
					end
				end
				amps_regs_pkg::ST_RD_BYTE: begin
					if (sclFall) begin
						if (bitCnt_ff == 4'(amps_regs_pkg::I2C_BITS)) begin
							nxt_st    = amps_regs_pkg::ST_ACK_RD;
							nxt_sdaOe = 1'b0;
							if (incEn_ff) begin
								nxt_ptr = ptr_ff + 7'h01;
							end
						end else begin
							nxt_sdaOe  = !shift_ff[7];
							nxt_shift  = {shift_ff[6:0], 1'b0};
							nxt_bitCnt = bitCnt_ff + 4'h1;
						end
					end
				end
				amps_regs_pkg::ST_ACK_RD: begin
					if (sclRise && sdaIn) begin
						nxt_st = amps_regs_pkg::ST_IDLE;
					end else if (loadRd) begin
						nxt_st     = amps_regs_pkg::ST_RD_BYTE;
						nxt_shift  = {rdData[6:0], 1'b0};
						nxt_sdaOe  = !rdData[7];
						nxt_bitCnt = 4'h1;
					end
				end
				default: begin
					nxt_st    = amps_regs_pkg::ST_IDLE;
					nxt_sdaOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff      <= amps_regs_pkg::ST_IDLE;
			shift_ff   <= 8'h00;
			bitCnt_ff  <= 4'h0;
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
			sdaOe_ff   <= 1'b0;
			ptr_ff     <= 7'h00;
			incEn_ff   <= 1'b1;
			gotPtr_ff  <= 1'b0;
			rw_ff      <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			shift_ff   <= nxt_shift;
			bitCnt_ff  <= nxt_bitCnt;
			sclPrev_ff <= sclIn;
			sdaPrev_ff <= sdaIn;
			sdaOe_ff   <= nxt_sdaOe;
			ptr_ff     <= nxt_ptr;
			incEn_ff   <= nxt_incEn;
			gotPtr_ff  <= nxt_gotPtr;
			rw_ff      <= nxt_rw;
		end
	end

	// writable fields; writes to read-only bits fall through untouched
	always_comb begin
		nxt_muteL   = muteL_ff;
		nxt_muteR   = muteR_ff;
		nxt_pllEn   = pllEn_ff;
		nxt_autoOff = autoOff_ff;
		nxt_legacy  = legacy_ff;
		if (wrEn) begin
			case (ptr_ff)
				amps_regs_pkg::OFS_BACKEND: begin
					nxt_muteL = shift_ff[amps_regs_pkg::BIT_MUTE_L];
					nxt_muteR = shift_ff[amps_regs_pkg::BIT_MUTE_R];
				end
				amps_regs_pkg::OFS_PLL: begin
					nxt_pllEn = shift_ff[amps_regs_pkg::BIT_PLL_EN];
				end
				amps_regs_pkg::OFS_OSC: begin
					nxt_autoOff = shift_ff[amps_regs_pkg::BIT_AUTO_OFF];
				end
				amps_regs_pkg::OFS_CTRLPORT: begin
					nxt_legacy = shift_ff[amps_regs_pkg::BIT_LEGACY];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			muteL_ff   <= amps_regs_pkg::RST_MUTE;
			muteR_ff   <= amps_regs_pkg::RST_MUTE;
			pllEn_ff   <= amps_regs_pkg::RST_PLL_EN;
			autoOff_ff <= amps_regs_pkg::RST_AUTO_OFF;
			legacy_ff  <= amps_regs_pkg::RST_LEGACY;
		end else begin
			muteL_ff   <= nxt_muteL;
			muteR_ff   <= nxt_muteR;
			pllEn_ff   <= nxt_pllEn;
			autoOff_ff <= nxt_autoOff;
			legacy_ff  <= nxt_legacy;
		end
	end

	// open drain: only ever pull low
	assign sdaOut = 1'b0;
	assign sdaOe  = sdaOe_ff;

	assign ctl.pllEnable  = pllEn_ff;
	assign ctl.extMclkSel = !pllEn_ff;
	assign ctl.oscSelect  = stat.sysClkBad;
	assign ctl.oscEnable  = !oscPoweredDown;
	// clock trouble takes the same standby path as the software request
	assign ctl.standby    = stat.swStandby || stat.sysClkBad;

	amps_mute_ramp #(
		.GAIN_W   (GAIN_W),
		.STEP_CYC (amps_regs_pkg::RAMP_STEP_CYC)
	) u_rampLeft (
		.clk     (clk),
		.sys_rst (sys_rst),
		.muteReq (muteL_ff),
		.gain    (gainLeft),
		.muted   ()
	);

	amps_mute_ramp #(
		.GAIN_W   (GAIN_W),
		.STEP_CYC (amps_regs_pkg::RAMP_STEP_CYC)
	) u_rampRight (
		.clk     (clk),
		.sys_rst (sys_rst),
		.muteReq (muteR_ff),
		.gain    (gainRight),
		.muted   ()
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_sync_mirror: assert property (rdData[7] == stat.syncClk || ptr_ff != amps_regs_pkg::OFS_BACKEND)
		else $error("sync bit does not follow sync clock");
	a_buffer_enable: assert property ((ptr_ff == amps_regs_pkg::OFS_BACKEND)
		|-> (rdData[6] == (stat.ldoInPor && stat.ldoOutPor)))
		else $error("buffer enable bit wrong");
	a_backend_power: assert property ((ptr_ff == amps_regs_pkg::OFS_BACKEND && !stat.lineAmpUnmuted)
		|-> !rdData[5])
		else $error("back end shown up while amps muted");
	a_left_mute_wr: assert property ((wrEn && ptr_ff == amps_regs_pkg::OFS_BACKEND)
		|=> (muteL_ff == $past(shift_ff[4])))
		else $error("left mute write lost");
	a_right_mute_wr: assert property ((wrEn && ptr_ff == amps_regs_pkg::OFS_BACKEND)
		|=> (muteR_ff == $past(shift_ff[0])))
		else $error("right mute write lost");
	a_unlock_when_off: assert property (!pllEn_ff |-> reg4Img[4])
		else $error("lock shown while PLL disabled");
	a_clk_source: assert property ((wrEn && ptr_ff == amps_regs_pkg::OFS_PLL)
		|=> (ctl.extMclkSel == !$past(shift_ff[0])))
		else $error("clock source not following PLL enable");
	a_osc_selected: assert property ($rose(stat.sysClkBad) |-> reg5Img[5] && ctl.oscSelect)
		else $error("oscillator selection not shown");
	a_osc_powerdown: assert property (stat.sysClkBad |-> !reg5Img[4] && ctl.oscEnable)
		else $error("oscillator down while selected");
	a_osc_always_on: assert property ((wrEn && ptr_ff == amps_regs_pkg::OFS_OSC && !shift_ff[0])
		|=> ctl.oscEnable)
		else $error("oscillator off with auto-off cleared");
	a_ptr_hold: assert property ((wrEn && !incEn_ff) |=> $stable(ptr_ff))
		else $error("pointer moved without auto-increment");
	a_ptr_always_inc: assert property ((ptrLoad && !legacy_ff) |=> incEn_ff)
		else $error("auto-increment off in default mode");
	a_clock_err_stby: assert property (stat.sysClkBad |-> ctl.standby)
		else $error("clock error without standby");
	a_reserved_zero: assert property ((reg3Img[3:1] == 3'h0) && (reg6Img[7:5] == 3'h0)
		&& (reg6Img[3:0] == 4'h0) && (reg5Img[7:6] == 2'h0))
		else $error("reserved bits not zero");

	c_reg_write: cover property (wrEn ##[1:400] wrEn);
	c_read_byte: cover property ((st_ff == amps_regs_pkg::ST_RD_BYTE) ##[1:400] (st_ff == amps_regs_pkg::ST_ACK_RD));
	c_legacy_noinc: cover property (ptrLoad && legacy_ff && !shift_ff[7]);
	c_clock_error: cover property ($rose(stat.sysClkBad));
endmodule // amps_regs
`default_nettype wire

// [logic/amps_regs_pkg.sv]
// constants and carrier types for the amplifier status, mute and clock registers
// What this block does
// - bit 7 of 0x03 mirrors back-end sync clock
// - bit 6 of 0x03: both regulator PORs seen
// - bit 5 of 0x03: supplies up, amps unmuted
// - bit 4 of 0x03 soft-mutes left channel
// - bit 0 of 0x03 soft-mutes right channel
// - 0x04 bit 4 unlocked flag, set when disabled
// - 0x04 bit 0 PLL enable; off selects external clock
// - 0x05 bit 5: fallback oscillator in use
// - 0x05 bit 4: oscillator auto-powered down
// - 0x05 bit 0 auto-off, else oscillator stays on
// - 0x06 bit 4 picks address auto-increment style
// - clock error forces system standby
`default_nettype none
package amps_regs_pkg;
	localparam logic [6:0] OFS_BACKEND  = 7'h03;
	localparam logic [6:0] OFS_PLL      = 7'h04;
	localparam logic [6:0] OFS_OSC      = 7'h05;
	localparam logic [6:0] OFS_CTRLPORT = 7'h06;

	localparam int BIT_SYNC      = 7;
	localparam int BIT_BUF_EN    = 6;
	localparam int BIT_BE_PWR    = 5;
	localparam int BIT_MUTE_L    = 4;
	localparam int BIT_MUTE_R    = 0;
	localparam int BIT_UNLOCKED  = 4;
	localparam int BIT_PLL_EN    = 0;
	localparam int BIT_OSC_SEL   = 5;
	localparam int BIT_OSC_PD    = 4;
	localparam int BIT_AUTO_OFF  = 0;
	localparam int BIT_LEGACY    = 4;
	localparam int BIT_AUTOINC   = 7;

	localparam logic RST_MUTE     = 1'h0;
	localparam logic RST_PLL_EN   = 1'h1;
	localparam logic RST_AUTO_OFF = 1'h1;
	localparam logic RST_LEGACY   = 1'h0;

	localparam int CLK_PERIOD_NS   = 25;
	localparam int RAMP_STEP_NS    = 2000;
	localparam int RAMP_STEP_CYC   = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int I2C_BITS        = 8;

	// inputs reported by the analog and clocking parts of the device
	typedef struct packed {
		logic syncClk;        // back-end sync clock, 98.304 MHz / 1024
		logic ldoInPor;       // regulator input power-on detected
		logic ldoOutPor;      // regulator output power-on detected
		logic avddPor;        // analog supply power-on detected
		logic cpvddPor;       // charge-pump supply power-on detected
		logic lineAmpUnmuted; // line amplifiers unmuted
		logic pllLocked;      // raw lock from the PLL
		logic sysClkBad;      // normal system clock missing or unreliable
		logic swStandby;      // software standby request
	} amps_stat_t;

	typedef struct packed {
		logic pllEnable;     // run the PLL
		logic extMclkSel;    // master clock taken from external input
		logic oscEnable;     // fallback oscillator powered
		logic oscSelect;     // fallback oscillator drives master clock
		logic standby;       // system standby
	} amps_ctl_t;

	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_ADDR    = 7'h02,
		ST_ACK_ADR = 7'h04,
		ST_WR_BYTE = 7'h08,
		ST_ACK_WR  = 7'h10,
		ST_RD_BYTE = 7'h20,
		ST_ACK_RD  = 7'h40
	} amps_i2c_st_t;
endpackage
`default_nettype wire

// [logic/amps_mute_ramp.sv]
// soft-mute volume ramp for one channel
`timescale 1ns/10ps
`default_nettype none
module amps_mute_ramp #(
	parameter int GAIN_W    = 8,
	parameter int STEP_CYC  = amps_regs_pkg::RAMP_STEP_CYC
) (
	input  wire logic              clk,      // master clock
	input  wire logic              sys_rst,  // async reset, high
	input  wire logic              muteReq,  // 1 ramps toward silence
	output logic      [GAIN_W-1:0] gain,     // current channel gain
	output logic                   muted     // gain reached zero
);
	localparam int CNT_W = $clog2(STEP_CYC + 1);
	localparam logic [GAIN_W-1:0] GAIN_MAX = {GAIN_W{1'b1}};

	if (GAIN_W < 2 || STEP_CYC < 1) begin : g_chk
		$error("amps_mute_ramp: unsupported parameters");
	end

	logic [GAIN_W-1:0] gain_ff;
	logic [GAIN_W-1:0] nxt_gain;
	logic [CNT_W-1:0]  stepCnt_ff;
	logic [CNT_W-1:0]  nxt_stepCnt;

	// one gain step per interval keeps the ramp free of clicks
	always_comb begin
		nxt_gain    = gain_ff;
		nxt_stepCnt = stepCnt_ff;
		if (stepCnt_ff == CNT_W'(STEP_CYC - 1)) begin
			nxt_stepCnt = '0;
			if (muteReq && gain_ff != '0) begin
				nxt_gain = gain_ff - GAIN_W'(1);
			end else if (!muteReq && gain_ff != GAIN_MAX) begin
				nxt_gain = gain_ff + GAIN_W'(1);
			end
		end else begin
			nxt_stepCnt = stepCnt_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gain_ff    <= {GAIN_W{1'b1}};
			stepCnt_ff <= '0;
		end else begin
			gain_ff    <= nxt_gain;
			stepCnt_ff <= nxt_stepCnt;
		end
	end

	assign gain  = gain_ff;
	assign muted = (gain_ff == '0);

	a_ramp_smooth: assert property (@(posedge clk) disable iff (sys_rst)
		(gain_ff == $past(gain_ff)) || (gain_ff == $past(gain_ff) + GAIN_W'(1))
		|| (gain_ff == $past(gain_ff) - GAIN_W'(1)))
		else $error("gain jumped more than one step");
endmodule // amps_mute_ramp
`default_nettype wire

// [sim/amps_i2c_host.sv]
// behavioural I2C host controller that reaches the register bank
`timescale 1ns/10ps
`default_nettype none
module amps_i2c_host (
	input  wire logic clk,   // bench clock, paces the bus
	input  wire logic sda,   // resolved data wire
	output var logic  scl,   // clock wire level, idles high
	output var logic  sdaOe  // high while pulling data low
);
	initial begin
		scl = 1'h1;
		sdaOe = 1'h0;
	end

	// four clocks per half bit, four times the minimum the bank needs to sample
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	task automatic bitX(input logic b, output logic r);
		sdaOe = ~b;
		half();
		scl = 1'h1;
		half();
		r = sda;
		scl = 1'h0;
		half();
	endtask

	// also used as repeated start, so data is released while clock is low
	task automatic startC();
		sdaOe = 1'h0;
		half();
		scl = 1'h1;
		half();
		sdaOe = 1'h1;
		half();
		scl = 1'h0;
		half();
	endtask

	task automatic stopC();
		sdaOe = 1'h1;
		half();
		scl = 1'h1;
		half();
		sdaOe = 1'h0;
		half();
	endtask

	task automatic sendByte(input logic [7:0] b, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitX(b[i], r);
		end
		bitX(1'h1, nack);
	endtask

	// last byte of a read gets a not-acknowledge, as the bus demands
	task automatic recvByte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitX(1'h1, d[i]);
		end
		bitX(last, r);
	endtask
endmodule // amps_i2c_host
`default_nettype wire

// [sim/test_amp_status_mute_clock_regs.sv]
// self-checking bench for the status, soft-mute and clock registers
`timescale 1ns/10ps
`default_nettype none
module test_amp_status_mute_clock_regs;
	localparam logic [4:0] ADDR_HI     = 5'h0B; // arbitrary upper address bits
	localparam int         CYCLE_LIMIT = 40000;

	logic                      clk = 1'h0;
	logic                      sys_rst = 1'h1;
	logic [1:0]                devAddrSel;
	logic                      scl;
	logic                      hostOe;
	logic                      dutOe;
	logic                      dutOut;
	wire logic                 sda;
	amps_regs_pkg::amps_stat_t stat;
	amps_regs_pkg::amps_ctl_t  ctl;
	logic [7:0]                gainLeft;
	logic [7:0]                gainRight;
	int                        mismatches = 0;
	int                        tests_run = 0;
	int                        cycles = 0;
	logic                      muteL;
	logic                      muteR;
	logic                      pllEn;
	logic                      autoOff;
	logic                      legacy;
	logic                      incMode;
	logic [6:0]                ptr;

	// pull-up on the data wire: high unless someone pulls it low
	assign sda = ~(hostOe | (dutOe & ~dutOut));

	amps_regs #(.DEV_ADDR_HI(ADDR_HI), .GAIN_W(8)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .devAddrSel(devAddrSel), .sclIn(scl), .sdaIn(sda),
		.sdaOut(dutOut), .sdaOe(dutOe), .stat(stat), .ctl(ctl), .gainLeft(gainLeft), .gainRight(gainRight));
	amps_i2c_host host_u (.clk(clk), .sda(sda), .scl(scl), .sdaOe(hostOe));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// reference image of each offset, from the model state and the status inputs
	function automatic logic [7:0] image(input logic [6:0] ofs);
		case (ofs)
			amps_regs_pkg::OFS_BACKEND: return {stat.syncClk, stat.ldoInPor & stat.ldoOutPor,
				stat.avddPor & stat.cpvddPor & stat.lineAmpUnmuted, muteL, 3'h0, muteR};
			amps_regs_pkg::OFS_PLL: return {3'h0, ~(pllEn & stat.pllLocked), 3'h0, pllEn};
			amps_regs_pkg::OFS_OSC: return {2'h0, stat.sysClkBad, autoOff & ~stat.sysClkBad, 3'h0, autoOff};
			amps_regs_pkg::OFS_CTRLPORT: return {3'h0, legacy, 4'h0};
			default: return 8'h00;
		endcase
	endfunction

	task automatic advance();
		if (!legacy || incMode) ptr = ptr + 7'h01;
	endtask

	task automatic setPtr(input logic [6:0] ofs, input logic inc);
		logic nack;
		host_u.startC();
		host_u.sendByte({ADDR_HI, devAddrSel, 1'h0}, nack);
		check({7'h00, nack}, 8'h00);
		host_u.sendByte({inc, ofs}, nack);
		check({7'h00, nack}, 8'h00);
		ptr = ofs;
		incMode = inc;
	endtask

	// data bits 4 and 0 come from fb, the rest random so read-only and reserved bits see writes
	task automatic wr(input logic [6:0] ofs, input logic inc, input int n, input logic [7:0] fb);
		logic       nack;
		logic [7:0] d;
		setPtr(ofs, inc);
		for (int i = 0; i < n; i++) begin
			d = (8'($urandom) & 8'hEE) | fb;
			host_u.sendByte(d, nack);
			check({7'h00, nack}, 8'h00);
			case (ptr)
				amps_regs_pkg::OFS_BACKEND: begin
					muteL = d[4];
					muteR = d[0];
				end
				amps_regs_pkg::OFS_PLL: pllEn = d[0];
				amps_regs_pkg::OFS_OSC: autoOff = d[0];
				amps_regs_pkg::OFS_CTRLPORT: legacy = d[4];
				default: ;
			endcase
			advance();
		end
		host_u.stopC();
	endtask

	task automatic rd(input logic [6:0] ofs, input logic inc, input int n);
		logic       nack;
		logic [7:0] d;
		setPtr(ofs, inc);
		host_u.startC();
		host_u.sendByte({ADDR_HI, devAddrSel, 1'h1}, nack);
		check({7'h00, nack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			host_u.recvByte(i == n - 1, d);
			check(d, image(ptr));
			advance();
		end
		host_u.stopC();
	endtask

	task automatic checkCtl();
		check({3'h0, ctl}, {3'h0, pllEn, ~pllEn, ~(autoOff & ~stat.sysClkBad), stat.sysClkBad,
			stat.swStandby | stat.sysClkBad});
	endtask

	initial begin
		logic nack;
		void'($urandom(86));
		devAddrSel = 2'($urandom);
		stat = 9'($urandom);
		muteL = amps_regs_pkg::RST_MUTE;
		muteR = amps_regs_pkg::RST_MUTE;
		pllEn = amps_regs_pkg::RST_PLL_EN;
		autoOff = amps_regs_pkg::RST_AUTO_OFF;
		legacy = amps_regs_pkg::RST_LEGACY;
		incMode = 1'h1;
		ptr = 7'h00;
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'h0;
		checkCtl();
		rd(7'h02, 1'h1, 6);
		// left mute alone: left ramps down one step per 80 clocks, right holds
		wr(amps_regs_pkg::OFS_BACKEND, 1'h1, 1, 8'h10);
		repeat (800) @(negedge clk);
		check({7'h00, gainLeft >= 8'hF4 && gainLeft <= 8'hF6}, 8'h01);
		check(gainRight, 8'hFF);
		wr(amps_regs_pkg::OFS_BACKEND, 1'h1, 1, 8'h01);
		repeat (1600) @(negedge clk);
		check(gainLeft, 8'hFF);
		check({7'h00, gainRight >= 8'hEA && gainRight <= 8'hEC}, 8'h01);
		// bursts across the whole bank with all four mixes of data bits 4 and 0 and a random increment bit
		for (int i = 0; i < 8; i++) begin
			stat = 9'($urandom);
			wr(amps_regs_pkg::OFS_BACKEND, 1'($urandom), 4, {3'h0, i[1], 3'h0, i[0]});
			checkCtl();
			rd(7'h02, 1'($urandom), 6);
		end
		// reset in mid-run with the bus idle: written fields and both ramps go back to reset state
		@(negedge clk);
		sys_rst = 1'h1;
		muteL = amps_regs_pkg::RST_MUTE;
		muteR = amps_regs_pkg::RST_MUTE;
		pllEn = amps_regs_pkg::RST_PLL_EN;
		autoOff = amps_regs_pkg::RST_AUTO_OFF;
		legacy = amps_regs_pkg::RST_LEGACY;
		repeat (4) @(negedge clk);
		sys_rst = 1'h0;
		check(gainLeft, 8'hFF);
		check(gainRight, 8'hFF);
		checkCtl();
		rd(7'h02, 1'h1, 6);
		// wrong device address is left unacknowledged
		host_u.startC();
		host_u.sendByte({ADDR_HI, ~devAddrSel, 1'h0}, nack);
		check({7'h00, nack}, 8'h01);
		host_u.stopC();
		complete_run();
	end
endmodule // test_amp_status_mute_clock_regs
`default_nettype wire
